// [rtl/alarm_bank.sv]
/*
 * Global interrupt register, config register four and clear-on-read alarm
 * status registers, one per alarm group.
 * Assumes one-cycle read and write pulses from the front end.
 */
`include "host_port_map.svh"
module alarm_bank (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [`ALARM_GROUPS*8-1:0] alarm_in,
   output      logic                  irq_pol_low,
   host_port_if.bank                  bus
);
   logic [7:0] stat_reg [`ALARM_GROUPS];
   logic [7:0] stat_next [`ALARM_GROUPS];
   logic [7:0] prev_reg [`ALARM_GROUPS];
   logic [7:0] cfg4_reg;
   logic [7:0] cfg4_next;
   logic [7:0] gint;

   genvar g;
   generate
      for (g = 0; g < `ALARM_GROUPS; g++) begin : grp
         logic [7:0] cond;
         logic [7:0] rise;
         logic       hit;
         assign cond = alarm_in[g*8 +: 8];
         assign rise = cond & ~prev_reg[g];
         assign hit  = bus.rd_pulse && (bus.addr == `ALARM_STAT_BASE + 12'(g));
         assign gint[g] = |stat_reg[g];
         always_comb begin
            // read clears only bits whose condition ended; new rises win
            stat_next[g] = hit ? ((stat_reg[g] & cond) | rise) : (stat_reg[g] | rise);
         end
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               stat_reg[g] <= 8'h00;
               prev_reg[g] <= 8'h00;
            end else begin
               stat_reg[g] <= stat_next[g];
               prev_reg[g] <= cond;
            end
         end
      end
      for (g = `ALARM_GROUPS; g < 8; g++) begin : pad
         assign gint[g] = 1'b0;
      end
   endgenerate

   always_comb begin
      cfg4_next = cfg4_reg;
      if (bus.wr_pulse && bus.addr == `GLOBAL_CFG4_ADDR)
         cfg4_next = bus.wdata;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         cfg4_reg <= `CFG4_RESET;
      else
         cfg4_reg <= cfg4_next;
   end

   always_comb begin
      bus.rdata = 8'h00;
      if (bus.addr == `GLOBAL_INT_ADDR)
         bus.rdata = gint;
      else if (bus.addr == `GLOBAL_CFG4_ADDR)
         bus.rdata = cfg4_reg;
      for (int i = 0; i < `ALARM_GROUPS; i++)
         if (bus.addr == `ALARM_STAT_BASE + 12'(i))
            bus.rdata = stat_reg[i];
   end
   assign bus.irq_any  = |gint;
   assign irq_pol_low  = cfg4_reg[`IRQ_POL_BIT];
endmodule // alarm_bank

// [rtl/host_port_if.sv]
/*
 * Carrier between the port front end and its alarm register bank.
 * Assumes a single clock domain.
 */
interface host_port_if;
   logic                  wr_pulse;
   logic                  rd_pulse;
   host_port_pkg::addr_t  addr;
   host_port_pkg::data_t  wdata;
   host_port_pkg::data_t  rdata;
   logic                  irq_any;
   modport front (output wr_pulse, rd_pulse, addr, wdata, input rdata, irq_any);
   modport bank  (input wr_pulse, rd_pulse, addr, wdata, output rdata, irq_any);
endinterface : host_port_if

// [rtl/host_port_map.svh]
/*
 * Constants of the host processor port: address layout, field positions,
 * reset values and timing counts.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

`define ADDR_W              12
`define DATA_W              8
`define ADDR_HI_LSB         8
// global interrupt register, config register four and alarm status register addresses
`define GLOBAL_INT_ADDR     12'h000
`define GLOBAL_CFG4_ADDR    12'h004
`define ALARM_STAT_BASE     12'h008
`define ALARM_GROUPS        4
`define IRQ_POL_BIT         6
`define CFG4_RESET          8'h00
`define NO_WAIT_MHZ         33
`define CLK_MHZ             100
// access waits ACK_DELAY_CYC clk cycles, one no-wait host cycle rounded up (4 at 100 MHz)
`define ACK_DELAY_CYC       ((`CLK_MHZ + `NO_WAIT_MHZ - 1) / `NO_WAIT_MHZ)

`endif

// [rtl/host_port_pkg.sv]
/*
 * Types of the host processor port.
 * Assumes host_port_map.svh for widths.
 */
`include "host_port_map.svh"
package host_port_pkg;
   typedef enum logic [1:0] {
      IDLE_S,
      ACCESS_S,
      DONE_S
   } cycle_state_t;
   typedef logic [`ADDR_W-1:0] addr_t;
   typedef logic [`DATA_W-1:0] data_t;
endpackage : host_port_pkg

// [rtl/host_processor_port.sv]
/*
 * Eight-bit host processor port with four strap-selected bus styles,
 * driving an alarm register bank and an interrupt output.
 * Assumes host pins are asynchronous to clk and are synchronised here.
 */
`include "host_port_map.svh"
module host_processor_port (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  bus_style_select,
   input  wire logic                  addr_data_share_select,
   input  wire logic                  chip_select_n,
   input  wire logic                  address_latch_strobe_n,
   input  wire logic                  store_or_data_strobe_n,
   input  wire logic                  read_or_rw,
   input  wire logic [3:0]            addr_hi,
   input  wire logic [7:0]            addr_lo,
   input  wire logic [7:0]            ad_in,
   output      logic [7:0]            ad_out,
   output      logic                  ad_oe_n,
   output      logic                  cycle_acknowledge,
   output      logic                  interrupt,
   input  wire logic [`ALARM_GROUPS*8-1:0] alarm_in
);
   // two-stage synchronisers on all host pins
   logic [4:0]  s1_reg;
   logic [4:0]  s2_reg;
   logic [19:0] sa1_reg;
   logic [19:0] sa2_reg;
   logic [1:0]  strap_reg;
   logic        cs, als, sds, rrw;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg  <= 5'h1F;
         s2_reg  <= 5'h1F;
         sa1_reg <= 20'h00000;
         sa2_reg <= 20'h00000;
      end else begin
         s1_reg  <= {chip_select_n, address_latch_strobe_n, store_or_data_strobe_n,
                     read_or_rw, 1'b1};
         s2_reg  <= s1_reg;
         sa1_reg <= {addr_hi, addr_lo, ad_in};
         sa2_reg <= sa1_reg;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         strap_reg <= 2'h0;
      else
         strap_reg <= {bus_style_select, addr_data_share_select};
   end
   logic [1:0] strap2_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         strap2_reg <= 2'h0;
      else
         strap2_reg <= strap_reg;
   end

   assign cs  = ~s2_reg[4];
   assign als = ~s2_reg[3];
   assign sds = ~s2_reg[2];
   assign rrw = s2_reg[1];

   logic style_rw;
   logic muxed;
   assign style_rw = ~strap2_reg[1];
   assign muxed    = strap2_reg[0];

   // roles of the shared pins by mode
   logic rd_act, wr_act;
   always_comb begin
      if (style_rw) begin
         rd_act = cs && sds && rrw;
         wr_act = cs && sds && !rrw;
      end else begin
         rd_act = cs && !rrw;
         wr_act = cs && sds;
      end
   end

   // address capture
   host_port_pkg::addr_t addr_reg, addr_next;
   logic                 als_d_reg;
   always_comb begin
      addr_next = addr_reg;
      if (muxed) begin
         if (cs && als)
            addr_next = {sa2_reg[19:16], sa2_reg[7:0]};
      end else if (als || !als_d_reg || !style_rw) begin
         // strobe low or tied low: address bus is live
         addr_next = sa2_reg[19:8];
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_reg  <= 12'h000;
         als_d_reg <= 1'b0;
      end else begin
         addr_reg  <= addr_next;
         als_d_reg <= als;
      end
   end

   host_port_if hp ();
   logic irq_pol_low;
   alarm_bank u_bank (
      .clk         (clk),
      .rst         (rst),
      .alarm_in    (alarm_in),
      .irq_pol_low (irq_pol_low),
      .bus         (hp.bank)
   );

   // access sequencer
   host_port_pkg::cycle_state_t state_reg, state_next;
   logic [1:0] cnt_reg, cnt_next;
   logic       wr_p, rd_p;
   logic       ack_next, ack_reg;
   logic [7:0] dout_next, dout_reg;
   logic       oe_n_next, oe_n_reg;

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      wr_p       = 1'b0;
      rd_p       = 1'b0;
      ack_next   = 1'b0;
      dout_next  = dout_reg;
      oe_n_next  = 1'b1;
      unique case (state_reg)
         host_port_pkg::IDLE_S: begin
            cnt_next = 2'h0;
            if (rd_act || wr_act)
               state_next = host_port_pkg::ACCESS_S;
         end
         host_port_pkg::ACCESS_S: begin
            if (!(rd_act || wr_act))
               state_next = host_port_pkg::IDLE_S;
            else if (cnt_reg == 2'(`ACK_DELAY_CYC - 1)) begin
               // one access per strobe assertion
               rd_p       = rd_act;
               wr_p       = wr_act;
               dout_next  = hp.rdata;
               state_next = host_port_pkg::DONE_S;
            end else
               cnt_next = cnt_reg + 2'h1;
            oe_n_next = !rd_act;
         end
         host_port_pkg::DONE_S: begin
            // acknowledge from clk, independent of the host clock
            ack_next  = rd_act || wr_act;
            oe_n_next = !rd_act;
            if (!(rd_act || wr_act))
               state_next = host_port_pkg::IDLE_S;
         end
         default: state_next = host_port_pkg::IDLE_S;
      endcase
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= host_port_pkg::IDLE_S;
         cnt_reg   <= 2'h0;
         ack_reg   <= 1'b0;
         dout_reg  <= 8'h00;
         oe_n_reg  <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         ack_reg   <= ack_next;
         dout_reg  <= dout_next;
         oe_n_reg  <= oe_n_next;
      end
   end
   assign hp.wr_pulse = wr_p;
   assign hp.rd_pulse = rd_p;
   assign hp.addr     = addr_reg;
   assign hp.wdata    = sa2_reg[7:0];

   // interrupt: set on rising alarm summary, held until a global read, a later read of any other address and a clear summary
   logic any_d_reg, gread_reg, gread_next, irq_reg, irq_next;
   logic sread_reg, sread_next;
   always_comb begin
      gread_next = gread_reg;
      sread_next = sread_reg;
      irq_next   = irq_reg;
      if (rd_p && addr_reg == `GLOBAL_INT_ADDR) begin
         gread_next = 1'b1;
         sread_next = 1'b0;
      end else if (rd_p && gread_reg) begin
         sread_next = 1'b1;
      end
      if (hp.irq_any && !any_d_reg) begin
         irq_next   = 1'b1;
         gread_next = 1'b0;
         sread_next = 1'b0;
      end else if (irq_reg && sread_reg && !hp.irq_any) begin
         // the status clear lands one cycle after the read pulse
         irq_next   = 1'b0;
         gread_next = 1'b0;
         sread_next = 1'b0;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         any_d_reg <= 1'b0;
         gread_reg <= 1'b0;
         sread_reg <= 1'b0;
         irq_reg   <= 1'b0;
      end else begin
         any_d_reg <= hp.irq_any;
         gread_reg <= gread_next;
         sread_reg <= sread_next;
         irq_reg   <= irq_next;
      end
   end

   logic irq_pin_reg, ack_pin_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_pin_reg <= 1'b0;
         ack_pin_reg <= 1'b1;
      end else begin
         irq_pin_reg <= irq_reg ^ irq_pol_low;
         // low-true acknowledge in style zero, high-true ready in style one
         ack_pin_reg <= style_rw ? !ack_next : ack_next;
      end
   end
   assign interrupt         = irq_pin_reg;
   assign cycle_acknowledge = ack_pin_reg;
   assign ad_out            = dout_reg;
   assign ad_oe_n           = oe_n_reg;

   cyc_once_a: assert property (@(posedge clk) disable iff (rst)
      (wr_p || rd_p) |=> !(wr_p || rd_p))
      else $error("access pulse repeated");
   irq_rise_a: assert property (@(posedge clk) disable iff (rst)
      (hp.irq_any && !any_d_reg) |=> irq_reg)
      else $error("interrupt not raised on new alarm");
   irq_hold_a: assert property (@(posedge clk) disable iff (rst)
      (irq_reg && !(sread_reg && !hp.irq_any)) |=> irq_reg)
      else $error("interrupt dropped without read");
   float_cs_a: assert property (@(posedge clk) disable iff (rst)
      !cs |=> ##1 ad_oe_n)
      else $error("data bus driven without chip select");
   ack_idle_a: assert property (@(posedge clk) disable iff (rst)
      (!cs && style_rw) |=> cycle_acknowledge)
      else $error("acknowledge asserted without chip select");
   rdy_idle_a: assert property (@(posedge clk) disable iff (rst)
      (!cs && !style_rw && $stable(style_rw)) |=> !cycle_acknowledge)
      else $error("ready asserted without chip select");
   pol_pin_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> interrupt == ($past(irq_reg) ^ $past(irq_pol_low)))
      else $error("interrupt polarity wrong");
   ack_after_a: assert property (@(posedge clk) disable iff (rst)
      (wr_p || rd_p) |=> (state_reg == host_port_pkg::DONE_S))
      else $error("no acknowledge phase after access");
endmodule // host_processor_port

// [test/host_master.sv]
/*
 * Host bus master model driving the port pins in any of the four bus styles.
 * Assumes the bench sets the straps to match the style and mux passed in.
 */
module host_master (
   input  wire logic       clk,
   input  wire logic       cycle_acknowledge,
   input  wire logic [7:0] ad_out,
   input  wire logic       ad_oe_n,
   output      logic       chip_select_n,
   output      logic       address_latch_strobe_n,
   output      logic       store_or_data_strobe_n,
   output      logic       read_or_rw,
   output      logic [3:0] addr_hi,
   output      logic [7:0] addr_lo,
   output      logic [7:0] ad_in
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      chip_select_n          = 1'b1;
      address_latch_strobe_n = 1'b1;
      store_or_data_strobe_n = 1'b1;
      read_or_rw             = 1'b1;
      addr_hi                = 4'h0;
      addr_lo                = 8'h00;
      ad_in                  = 8'h00;
   end

   // ready and acknowledge sampled on clk alone; no host clock is driven
   function automatic logic acked(input logic style);
      return style ? cycle_acknowledge : ~cycle_acknowledge;
   endfunction

   // one access; holds everything until the acknowledge is seen or 40 cycles pass, so slow answers stretch it
   task automatic access(input logic style, input logic mux, input logic wr,
                         input logic [11:0] addr, input logic [7:0] wdata,
                         output logic [7:0] rdata, output int lat, output logic oe_ok);
      @(posedge clk) #1;
      addr_hi                = addr[11:8];
      addr_lo                = mux ? ~addr[7:0] : addr[7:0];
      ad_in                  = mux ? addr[7:0] : (wr ? wdata : ~ad_in);
      read_or_rw             = style | ~wr;
      address_latch_strobe_n = 1'b0;
      chip_select_n          = 1'b0;
      if (mux) begin
         @(posedge clk) #1;
         address_latch_strobe_n = 1'b1;
         ad_in                  = wr ? wdata : ~addr[7:0];
      end
      @(posedge clk) #1;
      if (style && !wr)
         read_or_rw = 1'b0;
      else
         store_or_data_strobe_n = 1'b0;
      lat = 0;
      do begin
         @(posedge clk) #1;
         lat++;
      end while (!acked(style) && lat < 40);
      rdata                  = ad_out;
      oe_ok                  = (ad_oe_n === wr);
      store_or_data_strobe_n = 1'b1;
      if (style)
         read_or_rw = 1'b1;
      // keep select and address a while so clear-on-read sees a settled cycle
      repeat (2) @(posedge clk) #1;
      chip_select_n          = 1'b1;
      address_latch_strobe_n = 1'b1;
      read_or_rw             = 1'b1;
      addr_hi                = ~addr_hi;
      addr_lo                = ~addr_lo;
      ad_in                  = ~ad_in;
      for (int i = 0; i < 20 && acked(style); i++)
         @(posedge clk) #1;
   endtask

   // strobes with chip select high; quiet drops if the port reacts at all
   task automatic no_cs(input logic style, output logic quiet);
      quiet = 1'b1;
      @(posedge clk) #1;
      store_or_data_strobe_n = 1'b0;
      read_or_rw             = 1'b0;
      repeat (12) begin
         @(posedge clk) #1;
         if (acked(style) !== 1'b0 || ad_oe_n !== 1'b1)
            quiet = 1'b0;
      end
      store_or_data_strobe_n = 1'b1;
      read_or_rw             = 1'b1;
   endtask
endmodule // host_master

// [test/tb_top.sv]
/*
 * Self-checking bench for the host processor port: mode table, reset,
 * alarm interrupt sequence, polarity and chip-select isolation.
 * Assumes the host_master model drives all bus pins.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      logic        style;
      logic        mux;
      logic        wr;
      logic [11:0] addr;
      logic [7:0]  data;
   } row_t;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        bus_style_select = 1'b0;
   logic        addr_data_share_select = 1'b0;
   logic [31:0] alarm_in = 32'h0000_0000;
   logic        cs_n, ale_n, sd_n, rw, ack, oe_n, interrupt, quiet;
   logic [3:0]  a_hi;
   logic [7:0]  a_lo, ad_in, ad_out;
   int          bad_count = 0;
   int          num_checks = 0;
   int          cycles = 0;
   row_t        rows [12] = '{
      '{1'b0, 1'b0, 1'b1, 12'h004, 8'h15}, '{1'b0, 1'b0, 1'b0, 12'h004, 8'h15},
      '{1'b0, 1'b0, 1'b0, 12'h7FF, 8'h00}, '{1'b0, 1'b1, 1'b1, 12'h004, 8'h2A},
      '{1'b0, 1'b1, 1'b0, 12'h004, 8'h2A}, '{1'b0, 1'b1, 1'b0, 12'h0FF, 8'h00},
      '{1'b1, 1'b0, 1'b1, 12'h004, 8'h81}, '{1'b1, 1'b0, 1'b0, 12'h004, 8'h81},
      '{1'b1, 1'b0, 1'b0, 12'h5A5, 8'h00}, '{1'b1, 1'b1, 1'b1, 12'h004, 8'h3C},
      '{1'b1, 1'b1, 1'b0, 12'h004, 8'h3C}, '{1'b1, 1'b1, 1'b0, 12'h00B, 8'h00}};

   always #5 clk = ~clk;

   host_processor_port dut (.clk(clk), .rst(rst), .bus_style_select(bus_style_select),
      .addr_data_share_select(addr_data_share_select), .chip_select_n(cs_n),
      .address_latch_strobe_n(ale_n), .store_or_data_strobe_n(sd_n), .read_or_rw(rw),
      .addr_hi(a_hi), .addr_lo(a_lo), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(oe_n),
      .cycle_acknowledge(ack), .interrupt(interrupt), .alarm_in(alarm_in));

   host_master host (.clk(clk), .cycle_acknowledge(ack), .ad_out(ad_out), .ad_oe_n(oe_n),
      .chip_select_n(cs_n), .address_latch_strobe_n(ale_n), .store_or_data_strobe_n(sd_n),
      .read_or_rw(rw), .addr_hi(a_hi), .addr_lo(a_lo), .ad_in(ad_in));

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         bad_count++;
         report_and_stop();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask

   task automatic acc(input logic wr, input logic [11:0] addr, input logic [7:0] d);
      logic [7:0] rd;
      int         lat;
      logic       ok;
      host.access(bus_style_select, addr_data_share_select, wr, addr, d, rd, lat, ok);
      check({7'h00, lat <= 8}, 8'h01);
      check({7'h00, ok}, 8'h01);
      if (!wr)
         check(rd, d);
   endtask

   task automatic set_mode(input logic s, input logic m);
      @(posedge clk) #1;
      bus_style_select       = s;
      addr_data_share_select = m;
      repeat (4) @(posedge clk) #1;
   endtask

   task automatic do_reset();
      @(posedge clk) #1;
      rst = 1'b1;
      repeat (2) @(posedge clk) #1;
      check({6'h00, interrupt, oe_n}, 8'h01);
      repeat (6) @(posedge clk) #1;
      rst = 1'b0;
      repeat (3) @(posedge clk) #1;
   endtask

   task automatic irq_expect(input logic lvl);
      repeat (10) @(posedge clk) #1;
      check({7'h00, interrupt}, {7'h00, lvl});
   endtask

   task automatic raise();
      @(posedge clk) #1;
      alarm_in[11] = 1'b1;
      irq_expect(1'b1);
   endtask

   task automatic drop_and_clear();
      @(posedge clk) #1;
      alarm_in[11] = 1'b0;
      acc(1'b0, 12'h000, 8'h02);
      acc(1'b0, 12'h009, 8'h08);
      irq_expect(1'b0);
   endtask

   initial begin
      do_reset();
      foreach (rows[i]) begin
         if ({bus_style_select, addr_data_share_select} !== {rows[i].style, rows[i].mux})
            set_mode(rows[i].style, rows[i].mux);
         acc(rows[i].wr, rows[i].addr, rows[i].data);
      end
      $display("test mode table done");
      set_mode(1'b0, 1'b0);
      do_reset();
      acc(1'b0, 12'h004, 8'h00);
      acc(1'b1, 12'h004, 8'h00);
      $display("test reset done");
      raise();
      acc(1'b0, 12'h000, 8'h02);
      acc(1'b0, 12'h009, 8'h08);
      acc(1'b0, 12'h009, 8'h08);
      drop_and_clear();
      acc(1'b0, 12'h009, 8'h00);
      raise();
      drop_and_clear();
      $display("test alarm done");
      acc(1'b1, 12'h004, 8'h40);
      irq_expect(1'b1);
      acc(1'b1, 12'h004, 8'h00);
      irq_expect(1'b0);
      $display("test polarity done");
      for (int s = 0; s < 2; s++) begin
         set_mode(s[0], 1'b0);
         host.no_cs(s[0], quiet);
         check({7'h00, quiet}, 8'h01);
      end
      $display("test chip select done");
      report_and_stop();
   end
endmodule // tb_top
